/* rtl/vsfs_frame_sync.sv */
// Video stream frame and line sync checker with recovery and lane packing
// Assumes one clock, AHB-Lite register access, stream partners on same clock
`include "vsfs_defines.svh"

// Contract
// RULE_01: Beat moves when ready, valid and released reset meet at an edge.
// RULE_02: A sender holds valid and payload steady until ready is seen high.
// RULE_03: Ports use continuous aligned packed data, bus a multiple of 8 bits.
// RULE_04: Frame start rides on user bit 0, marking first pixel of a frame.
// RULE_05: Frame start is high on exactly one beat, the frame's first pixel.
// RULE_06: Frame start belongs to the lowest byte of its beat.
// RULE_07: Sender may raise frame start early while valid stays low.
// RULE_08: Receiver predicts frame start; early or missing start is an error.
// RULE_09: Early and late frame start set separate sticky error flags.
// RULE_10: Every early or late flag can signal the processor.
// RULE_11: Early start ends old frame with line end, new frame starts at once.
// RULE_12: Late start drops accepted pixels until a frame start arrives.
// RULE_13: Line end on last marks exactly the last pixel of each line.
// RULE_14: Receiver predicts line end; early or missing line end is an error.
// RULE_15: Early and late line end set separate sticky error flags.
// RULE_16: Early line end flushes, tags the line end, starts new line.
// RULE_17: Late line end emits end at set length, drops until input end.
// RULE_18: No real-time demand beyond the handshake and the clock.
// RULE_19: Pixel data is one undivided port.
// RULE_20: Bus width is a parameter, component width times component count.
// RULE_21: Component width is 8, 10, 12 or 16 bits.
// RULE_22: The propagated format code may be checked against the expected one.
// RULE_23: Lanes by format code: code 0 luma low; code 2 green, blue, red.
// RULE_24: Code 13 is luma only; codes 14 and 15 are never checked.
// RULE_25: Pixel and line counters reset at reset and frame start.
module vsfs_frame_sync #(
	parameter int         P_COMP_W  = 8,              // Component width
	parameter int         P_BUS_W   = 24,             // Pixel bus width
	parameter logic [3:0] P_FORMAT  = `VSFS_FMT_RGB,  // Format from upstream
	parameter logic [3:0] P_EXP_FMT = `VSFS_FMT_RGB   // Format expected
) (
	input  wire logic                  i_clk_sys,     // System clock
	input  wire logic                  i_rst_n,       // Async reset, low
	input  wire logic                  i_hsel,        // Slave select
	input  wire logic [7:0]            i_haddr,       // Byte address
	input  wire logic [1:0]            i_htrans,      // Transfer type
	input  wire logic                  i_hwrite,      // Write strobe
	input  wire logic [2:0]            i_hsize,       // Size, words only
	input  wire logic [31:0]           i_hwdata,      // Write data
	input  wire logic                  i_hready,      // Bus ready
	output logic                       o_hreadyout,   // Slave ready
	output logic                       o_hresp,       // Always OKAY
	output logic [31:0]                o_hrdata,      // Read data
	input  wire logic                  i_s_tvalid,    // Input valid
	output logic                       o_s_tready,    // Input ready
	input  wire logic [P_BUS_W-1:0]    i_s_tdata,     // Input pixel
	input  wire logic                  i_s_tuser,     // Input frame start
	input  wire logic                  i_s_tlast,     // Input line end
	output logic                       o_m_tvalid,    // Output valid
	input  wire logic                  i_m_tready,    // Output ready
	output logic [P_BUS_W-1:0]         o_m_tdata,     // Output pixel
	output logic                       o_m_tuser,     // Output frame start
	output logic                       o_m_tlast,     // Output line end
	output vsfs_pkg::vsfs_err_t        o_err_flags,   // Sticky error flags
	output vsfs_pkg::vsfs_state_t      o_state        // Recovery state
);
	import vsfs_pkg::*;

	localparam int P_NLANE = P_BUS_W / P_COMP_W;

	// ****************************************
	// Lane decoding
	// ****************************************

	// Number of lanes a format carries; user codes keep up to four lanes
	function automatic logic [2:0] lanes_of(input logic [3:0] fmt);
		case (fmt)
			4'h0, 4'h3, 4'h7:               lanes_of = 3'd2;
			4'h1, 4'h2, 4'h4, 4'h8, 4'hB:   lanes_of = 3'd3;
			4'h5, 4'h6, 4'h9, 4'hA:         lanes_of = 3'd4;
			4'hC, 4'hD:                     lanes_of = 3'd1;
			default:                        lanes_of = 3'd4;
		endcase
	endfunction

	logic [P_BUS_W-1:0] packed_data;

	// Keep lanes in use, zero the rest; positions follow the code [RULE_23]
	genvar j;
	generate
		for (j = 0; j < P_NLANE; j++) begin : g_lane
			assign packed_data[j*P_COMP_W +: P_COMP_W] =
				(j < int'(lanes_of(P_FORMAT))) ?
				i_s_tdata[j*P_COMP_W +: P_COMP_W] : '0; // [RULE_24]
		end
		if (P_BUS_W > P_NLANE * P_COMP_W) begin : g_pad
			assign packed_data[P_BUS_W-1:P_NLANE*P_COMP_W] = '0; // [RULE_03]
		end
	endgenerate

	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] frame_w;
	logic [15:0] frame_h;
	vsfs_err_t   err;
	vsfs_err_t   evt;
	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic [15:0] next_w;
	logic [15:0] next_h;
	vsfs_err_t   next_err;
	logic [15:0] pix;
	logic [15:0] line;
	vsfs_state_t state;

	// Address phase is taken when selected, ready and NONSEQ or SEQ (i_htrans[1] set)
	wire addr_ok = i_hsel & i_hready & i_htrans[1];

	// Write values seen in the data phase, used also to forward reads
	always_comb begin
		next_w   = frame_w;
		next_h   = frame_h;
		next_err = err | evt;
		if (wr_pend && wr_addr == `VSFS_ADDR_WIDTH)
			next_w = i_hwdata[15:0];
		if (wr_pend && wr_addr == `VSFS_ADDR_HEIGHT)
			next_h = i_hwdata[15:0];
		if (wr_pend && wr_addr == `VSFS_ADDR_ERROR)
			next_err = (err & ~i_hwdata[3:0]) | evt; // [RULE_09] [RULE_15]
	end

	// Data phase tracking of writes
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= addr_ok & i_hwrite;
			wr_addr <= i_haddr;
		end
	end

	// Configuration and sticky error storage
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			frame_w <= `VSFS_WIDTH_RST;
			frame_h <= `VSFS_HEIGHT_RST;
			err     <= '0;
		end else begin
			frame_w <= next_w;
			frame_h <= next_h;
			err     <= next_err;
		end
	end

	// Read data launched at the address phase, zero wait states
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hrdata    <= 32'h00000000;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
			o_err_flags <= '0;
		end else begin
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
			o_err_flags <= next_err; // [RULE_10]
			if (addr_ok && !i_hwrite) begin
				case (i_haddr)
					`VSFS_ADDR_WIDTH:  o_hrdata <= {16'h0000, next_w};
					`VSFS_ADDR_HEIGHT: o_hrdata <= {16'h0000, next_h};
					`VSFS_ADDR_ERROR:  o_hrdata <= {28'h0000000, next_err};
					`VSFS_ADDR_POS:    o_hrdata <= {line, pix};
					`VSFS_ADDR_STATE:  o_hrdata <= {30'h0000000, state};
					default:           o_hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ****************************************
	// Frame and line tracking
	// ****************************************
	logic        p_v;
	logic [P_BUS_W-1:0] p_data;
	logic        p_user;
	logic        p_last;
	logic        acc;
	logic        fwd;
	logic        force_prev;
	logic        in_last;
	logic        move;
	logic        next_p_v;
	logic        next_o_v;
	logic [15:0] bpix;
	logic [15:0] bline;
	logic [15:0] next_pix;
	logic [15:0] next_line;
	vsfs_state_t next_state;

	wire exp_sof  = (pix == 16'h0000) && (line == 16'h0000);
	wire out_free = ~o_m_tvalid | i_m_tready;

	// Classify each accepted beat against the predicted position
	always_comb begin
		acc        = i_s_tvalid & o_s_tready; // [RULE_01]
		fwd        = 1'b0;
		force_prev = 1'b0;
		in_last    = i_s_tlast;
		evt        = '0;
		next_state = state;
		next_pix   = pix;
		next_line  = line;
		bpix       = i_s_tuser ? 16'h0000 : pix; // [RULE_25]
		bline      = i_s_tuser ? 16'h0000 : line;
		if (acc) begin
			if (state == VSFS_RUN || i_s_tuser) begin
				if (i_s_tuser && !exp_sof) begin
					evt[`VSFS_ERR_SOF_EARLY] = 1'b1; // [RULE_08]
					force_prev = 1'b1;                // [RULE_11]
				end
				if (!i_s_tuser && exp_sof) begin
					evt[`VSFS_ERR_SOF_LATE] = 1'b1;   // [RULE_08]
					next_state = VSFS_WAIT_SOF;       // [RULE_12]
				end else begin
					fwd        = 1'b1;
					next_state = VSFS_RUN;
					next_pix   = bpix + 16'h0001;
					if (i_s_tlast && bpix != frame_w - 16'h0001)
						evt[`VSFS_ERR_EOL_EARLY] = 1'b1; // [RULE_14] [RULE_16]
					if (!i_s_tlast && bpix == frame_w - 16'h0001) begin
						evt[`VSFS_ERR_EOL_LATE] = 1'b1;  // [RULE_14]
						in_last    = 1'b1;               // [RULE_17]
						next_state = VSFS_DROP_LINE;
					end
					if (in_last) begin
						next_pix  = 16'h0000;            // [RULE_13]
						next_line = (bline == frame_h - 16'h0001) ?
							16'h0000 : bline + 16'h0001;
					end else begin
						next_line = bline;
					end
				end
			end else if (state == VSFS_DROP_LINE) begin
				if (i_s_tlast)
					next_state = VSFS_RUN;               // [RULE_17]
			end
		end
	end

	// Recovery state and position counters
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state   <= VSFS_RUN;
			o_state <= VSFS_RUN;
			pix     <= 16'h0000;
			line    <= 16'h0000;
		end else begin
			state   <= next_state;
			o_state <= next_state;
			pix     <= next_pix;  // [RULE_25]
			line    <= next_line;
		end
	end

	// ****************************************
	// Hold stage and output stage
	// ****************************************

	// Held beat leaves on a line end, a forced end or the next forwarded beat
	always_comb begin
		move     = p_v & out_free & (p_last | force_prev | fwd);
		next_p_v = fwd | (p_v & ~move);
		next_o_v = move | (o_m_tvalid & ~i_m_tready);
	end

	// Hold register keeps the newest beat so a frame can still be closed
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			p_v    <= 1'b0;
			p_data <= '0;
			p_user <= 1'b0;
			p_last <= 1'b0;
		end else begin
			p_v <= next_p_v;
			if (fwd) begin
				p_data <= packed_data;   // [RULE_19]
				p_user <= i_s_tuser;     // [RULE_04] [RULE_06]
				p_last <= in_last;
			end
		end
	end

	// Output register, held steady while the consumer stalls
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_m_tvalid <= 1'b0;
			o_m_tdata  <= '0;
			o_m_tuser  <= 1'b0;
			o_m_tlast  <= 1'b0;
		end else begin
			o_m_tvalid <= next_o_v;      // [RULE_02]
			if (move) begin
				o_m_tdata <= p_data;
				o_m_tuser <= p_user;     // [RULE_05]
				o_m_tlast <= p_last | force_prev; // [RULE_11]
			end
		end
	end

	// Ready depends only on internal room, never on input valid
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			o_s_tready <= 1'b0;
		else
			o_s_tready <= ~next_p_v | ~next_o_v; // [RULE_18]
	end

	// ****************************************
	// Checks
	// ****************************************
	// Properties sample at the rising edge, idle in reset
	a_out_hold: assert property ( // [RULE_02]
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_m_tvalid && !i_m_tready |=> o_m_tvalid && $stable(o_m_tdata)
			&& $stable(o_m_tlast) && $stable(o_m_tuser))
		else $error("output changed while stalled");
	a_no_overrun: assert property ( // [RULE_01]
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		acc |-> !p_v || !o_m_tvalid)
		else $error("beat accepted without room");
	a_sof_early: assert property ( // [RULE_09]
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		acc && i_s_tuser && !exp_sof |=> err[`VSFS_ERR_SOF_EARLY]
			&& pix == ($past(i_s_tlast) ? 16'h0000 : 16'h0001))
		else $error("early frame start not flagged");
	// Late start: the beat is dropped in the cycle it is taken
	a_sof_late: assert property ( // [RULE_12]
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		acc && !i_s_tuser && exp_sof && state == VSFS_RUN |-> !fwd ##1
			err[`VSFS_ERR_SOF_LATE] && state == VSFS_WAIT_SOF)
		else $error("late frame start not handled");
	a_eol_late: assert property ( // [RULE_17]
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		fwd && !i_s_tlast && bpix == frame_w - 16'h0001 |=>
			err[`VSFS_ERR_EOL_LATE] && p_last && state == VSFS_DROP_LINE)
		else $error("late line end not forced");
	a_eol_early: assert property ( // [RULE_15]
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		fwd && i_s_tlast && bpix != frame_w - 16'h0001 |=>
			err[`VSFS_ERR_EOL_EARLY] && pix == 16'h0000)
		else $error("early line end not flagged");
	a_err_sticky: assert property ( // [RULE_09]
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		err[0] && !(wr_pend && wr_addr == `VSFS_ADDR_ERROR && i_hwdata[0])
			|=> err[0])
		else $error("error flag lost");
	a_drop_wait: assert property ( // [RULE_12]
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		state == VSFS_WAIT_SOF && acc && !i_s_tuser |-> !fwd ##1
			state == VSFS_WAIT_SOF)
		else $error("pixel forwarded while waiting for start");
	// Parameter checks, held on every cycle
	a_format_ok: assert property ( // [RULE_22]
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		P_EXP_FMT >= `VSFS_FMT_USER0 || P_FORMAT == P_EXP_FMT)
		else $error("format code mismatch");
	a_comp_width: assert property ( // [RULE_21]
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(P_COMP_W == 8 || P_COMP_W == 10 || P_COMP_W == 12 || P_COMP_W == 16)
			&& P_BUS_W % 8 == 0 && P_BUS_W >= P_COMP_W) // [RULE_20]
		else $error("unsupported component or bus width");
	// Only lane zero may carry data in luma-only format
	a_luma_only: assert property ( // [RULE_24]
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_m_tvalid && P_FORMAT == `VSFS_FMT_LUMA |->
			(o_m_tdata >> P_COMP_W) == '0)
		else $error("luma only beat has upper lanes");
endmodule

/* rtl/vsfs_defines.svh */
// Offsets, field positions, reset values and format codes of the frame sync
// Assumes inclusion by bare name from the design module
`ifndef VSFS_DEFINES_SVH
`define VSFS_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define VSFS_ADDR_WIDTH   8'h00
`define VSFS_ADDR_HEIGHT  8'h04
`define VSFS_ADDR_ERROR   8'h08
`define VSFS_ADDR_POS     8'h0C
`define VSFS_ADDR_STATE   8'h10

// ****************************************
// Reset values and error bit positions
// ****************************************
`define VSFS_WIDTH_RST    16'h0010
`define VSFS_HEIGHT_RST   16'h0008
`define VSFS_ERR_SOF_EARLY 0
`define VSFS_ERR_SOF_LATE  1
`define VSFS_ERR_EOL_EARLY 2
`define VSFS_ERR_EOL_LATE  3

// ****************************************
// Format codes
// ****************************************
`define VSFS_FMT_YUV422   4'h0
`define VSFS_FMT_RGB      4'h2
`define VSFS_FMT_LUMA     4'hD
`define VSFS_FMT_USER0    4'hE
`define VSFS_FMT_USER1    4'hF

`endif

/* rtl/vsfs_pkg.sv */
// Types shared by the frame sync block
// Assumes the defines header is on the include path
package vsfs_pkg;
	typedef enum logic [1:0] {
		VSFS_RUN       = 2'b00,
		VSFS_DROP_LINE = 2'b01,
		VSFS_WAIT_SOF  = 2'b10
	} vsfs_state_t;
	typedef logic [3:0] vsfs_err_t;
endpackage

/* tb/vsfs_sink_model.sv */
// Downstream stream sink that stalls one cycle in three and logs beats
// Assumes the same clock and reset as the frame sync block
module vsfs_sink_model (
	input  wire logic        i_clk_sys, // System clock
	input  wire logic        i_rst_n,   // Async reset, low
	input  wire logic        i_tvalid,  // Beat valid
	input  wire logic [23:0] i_tdata,   // Pixel
	input  wire logic        i_tuser,   // Frame start
	input  wire logic        i_tlast,   // Line end
	output logic             o_tready   // Sink ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [25:0] got[$];
	logic [1:0]  phase;
	// Stall pattern keeps the output stage holding its beat
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase <= 2'h0;
			o_tready <= 1'b0;
		end else begin
			phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
			o_tready <= (phase != 2'h2);
		end
	end
	// Log a beat only on a full handshake, as {user, last, data}
	always @(posedge i_clk_sys) begin
		if (i_rst_n && i_tvalid && o_tready) begin
			got.push_back({i_tuser, i_tlast, i_tdata});
		end
	end
endmodule

/* tb/test_video_stream_frame_sync.sv */
// Self-checking bench for the frame sync: registers, stream and recovery
// Assumes the design's defaults of 24-bit pixels in format code 2
module test_video_stream_frame_sync;
	timeunit 1ns;
	timeprecision 1ps;
	import vsfs_pkg::*;
	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
	} vsfs_row_t;
	logic        clk, rst_n, hsel, hwrite, hrdy, hresp;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [31:0] hwdata, hrdata, r;
	logic        s_tvalid, s_tready, s_tuser, s_tlast;
	logic        m_tvalid, m_tready, m_tuser, m_tlast;
	logic [23:0] s_tdata, m_tdata, l_tdata;
	logic        l_tvalid;
	logic        l_seen = 1'b0;
	vsfs_err_t   err;
	vsfs_state_t st;
	logic [25:0] exp_q[$];
	int          n_errors, total_checks;
	vsfs_row_t   rows[13];

	vsfs_frame_sync dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
		.o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
		.i_s_tvalid(s_tvalid), .o_s_tready(s_tready), .i_s_tdata(s_tdata),
		.i_s_tuser(s_tuser), .i_s_tlast(s_tlast), .o_m_tvalid(m_tvalid),
		.i_m_tready(m_tready), .o_m_tdata(m_tdata), .o_m_tuser(m_tuser),
		.o_m_tlast(m_tlast), .o_err_flags(err), .o_state(st));
	vsfs_sink_model sink_u (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_tvalid(m_tvalid), .i_tdata(m_tdata), .i_tuser(m_tuser),
		.i_tlast(m_tlast), .o_tready(m_tready));
	// Luma-only instance on the same input stream, output always taken
	vsfs_frame_sync #(.P_FORMAT(4'hD), .P_EXP_FMT(4'hD)) dut_luma (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_hsel(1'b0),
		.i_haddr(8'h00), .i_htrans(2'h0), .i_hwrite(1'b0),
		.i_hsize(3'h2), .i_hwdata(32'h0), .i_hready(1'b1),
		.o_hreadyout(), .o_hresp(), .o_hrdata(),
		.i_s_tvalid(s_tvalid), .o_s_tready(), .i_s_tdata(s_tdata),
		.i_s_tuser(s_tuser), .i_s_tlast(s_tlast), .o_m_tvalid(l_tvalid),
		.i_m_tready(1'b1), .o_m_tdata(l_tdata), .o_m_tuser(),
		.o_m_tlast(), .o_err_flags(), .o_state());
	// Remember that the luma instance produced a beat
	always @(posedge clk) begin
		if (l_tvalid === 1'b1)
			l_seen <= 1'b1;
	end

	// ************************************************
	// Clock and shared tasks
	// ************************************************
	always #2 clk = ~clk;
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	// Wait for bus ready (0) or input ready (1), sampled before the edge
	task automatic wait_hi(input logic sel);
		int i;
		for (i = 0; i < 50; i++) begin
			@(negedge clk);
			if ((sel ? s_tready : hrdy) === 1'b1) break;
			@(posedge clk);
		end
		@(posedge clk);
		if (i == 50) begin
			n_errors++;
			summarize();
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_hi(1'b0);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_hi(1'b0);
		r = hrdata;
	endtask
	// One beat held until taken; k says whether it should come out
	task automatic beat(input logic [23:0] d, input logic u, l, k, eu, el);
		s_tvalid <= 1'b1;
		s_tdata <= d;
		s_tuser <= u;
		s_tlast <= l;
		wait_hi(1'b1);
		if (k) exp_q.push_back({eu, el, d});
	endtask
	task automatic line(input logic [23:0] b, input logic u);
		for (int i = 0; i < 4; i++) beat(b + 24'(i), u && i == 0, i == 3,
			1'b1, u && i == 0, i == 3);
	endtask
	// Release the bus, wait for output, compare beats and flags
	task automatic drain(input vsfs_err_t ef);
		int i;
		s_tvalid <= 1'b0;
		s_tuser <= 1'b0;
		s_tlast <= 1'b0;
		s_tdata <= ~s_tdata;
		for (i = 0; i < 100 && sink_u.got.size() < exp_q.size(); i++)
			@(posedge clk);
		if (sink_u.got.size() < exp_q.size()) begin
			n_errors++;
			summarize();
		end
		repeat (4) @(posedge clk);
		check(32'(sink_u.got.size()), 32'(exp_q.size()));
		while (exp_q.size() > 0 && sink_u.got.size() > 0)
			check(32'(sink_u.got.pop_front()), 32'(exp_q.pop_front()));
		check(32'(err), 32'(ef));
		sink_u.got.delete();
		exp_q.delete();
		ahb(1'b1, 8'h08, 32'h0000000F);
	endtask

	// ************************************************
	// Main sequence
	// ************************************************
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{hsel, hwrite, haddr, htrans, hwdata} = '0;
		{s_tvalid, s_tdata, s_tuser, s_tlast} = '0;
		n_errors = 0;
		total_checks = 0;
		rows = '{'{1'h0, 8'h00, 32'h0, 32'h10}, '{1'h0, 8'h04, 32'h0, 32'h8},
			'{1'h0, 8'h08, 32'h0, 32'h0}, '{1'h0, 8'h0C, 32'h0, 32'h0},
			'{1'h0, 8'h10, 32'h0, 32'h0}, '{1'h1, 8'h14, 32'hFF, 32'h0},
			'{1'h0, 8'h14, 32'h0, 32'h0}, '{1'h1, 8'h0C, 32'h55, 32'h0},
			'{1'h0, 8'h0C, 32'h0, 32'h0}, '{1'h1, 8'h00, 32'h4, 32'h0},
			'{1'h0, 8'h00, 32'h0, 32'h4}, '{1'h1, 8'h04, 32'h2, 32'h0},
			'{1'h0, 8'h04, 32'h0, 32'h2}};
		repeat (2) @(posedge clk);
		check(32'(s_tready), 32'h0);
		check(32'(err), 32'h0);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		foreach (rows[i]) begin
			ahb(rows[i].w, rows[i].a, rows[i].d);
			check(32'(hresp), 32'h0);
			if (!rows[i].w) check(r, rows[i].e);
		end
		$display("test registers done");
		// Frame start raised while valid is still low
		s_tuser <= 1'b1;
		repeat (3) @(posedge clk);
		line(24'h000100, 1'b1);
		line(24'h000200, 1'b0);
		drain(4'h0);
		check(32'(l_seen), 32'h1);
		check(32'(l_tdata[23:8]), 32'h0);
		$display("test clean frame done");
		// Stray beat before the next frame start is dropped
		beat(24'h000300, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		repeat (3) @(posedge clk);
		check(32'(st), 32'(VSFS_WAIT_SOF));
		line(24'h000400, 1'b1);
		line(24'h000500, 1'b0);
		drain(4'h2);
		$display("test late frame start done");
		// Line ends after two pixels, next line is full
		beat(24'h000600, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		beat(24'h000601, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		line(24'h000700, 1'b0);
		drain(4'h4);
		$display("test early line end done");
		// Missing line end is forced at length four, rest dropped
		for (int i = 0; i < 4; i++) beat(24'h000800 + 24'(i), i == 0, 1'b0,
			1'b1, i == 0, i == 3);
		beat(24'h000804, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		check(32'(st), 32'(VSFS_DROP_LINE));
		beat(24'h000805, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		line(24'h000900, 1'b0);
		drain(4'h8);
		$display("test late line end done");
		// New frame start in mid-line closes the old frame
		beat(24'h000A00, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		beat(24'h000A01, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
		line(24'h000B00, 1'b1);
		line(24'h000C00, 1'b0);
		drain(4'h1);
		$display("test early frame start done");
		// Reset in mid-run restores state, flags and width
		beat(24'h000D00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		s_tvalid <= 1'b0;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		check(32'(err), 32'h0);
		check(32'(st), 32'(VSFS_RUN));
		ahb(1'b0, 8'h00, 32'h0);
		check(r, 32'h10);
		$display("test second reset done");
		summarize();
	end
endmodule
